// >>> verilog/pmrs_pkg.sv
package pmrs_pkg;

  // ****************************************************************
  // clock and sequence timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US = 1000;
  // stabilization choices, in microseconds
  localparam int STAB0_US = 140;
  localparam int STAB1_US = 4500;
  localparam int STAB2_US = 18000;
  localparam int STAB3_US = 72000;
  localparam int STAB4_US = 288000;
  // least times, rounded up to whole cycles
  localparam int STAB0_CYCLES =
    (STAB0_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB1_CYCLES =
    (STAB1_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB2_CYCLES =
    (STAB2_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB3_CYCLES =
    (STAB3_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB4_CYCLES =
    (STAB4_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OST_CYCLES = 16;
  localparam int WAKE_CYCLES = 16;
  localparam int CNT_W = 32;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
  localparam logic [7:0] ADDR_INT_EN = 8'h10;
  localparam logic [7:0] ADDR_INT_CLR = 8'h14;

  // control fields
  localparam int CTRL_SEL_HIGH = 0;
  localparam int CTRL_STOP_HOSC = 1;
  localparam int CTRL_OPMD_LO = 2;
  localparam int CTRL_TIMER0_ENABLE = 4;
  localparam int CTRL_TIMER1_ENABLE = 5;
  localparam int CTRL_WATCHDOG_ENABLE = 6;
  localparam int CTRL_MOD_LO = 8;
  localparam int MOD_EN_W = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0040;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0f73;
  localparam logic [1:0] OPMD_HALT = 2'h1;
  localparam logic [1:0] OPMD_STANDBY = 2'h2;

  // configuration fields
  localparam int CFG_STAB_LO = 0;
  localparam int CFG_STARTUP_HIGH = 3;
  localparam int CFG_WDT_OPT = 4;
  localparam int CFG_WDT_RESET = 5;
  localparam logic [31:0] CFG_RST = 32'h0000_0038;
  localparam logic [31:0] CFG_WMASK = 32'h0000_003f;

  // status fields and mode codes
  localparam int STAT_MODE_LO = 0;
  localparam int STAT_IN_RESET = 2;
  localparam int STAT_PD_N = 3;
  localparam int STAT_TO_N = 4;
  localparam int STAT_CAUSE_LO = 5;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLOW = 2'h1;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] MODE_HALT = 2'h3;

  // interrupt bits
  localparam int INT_WAKE = 0;
  localparam int INT_RST_DONE = 1;
  localparam int INT_WDT = 2;
  localparam int INT_W = 3;

  typedef enum logic [2:0] {
    S_RESET, S_STAB, S_OST, S_NORMAL, S_SLOW, S_STANDBY, S_HALT, S_WAKE
  } pmrs_state_t;

endpackage : pmrs_pkg

// >>> verilog/pmrs_sync2.sv
`timescale 1ns/1ps
module pmrs_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // ****************************************************************
  // two flip-flop synchroniser, one per bit
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // first stage feeds only the second stage
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_reg <= RST_VAL[gi];
          sync_reg <= RST_VAL[gi];
        end else begin
          meta_reg <= async_i[gi];
          sync_reg <= meta_reg;
        end
      end
      assign sync_o[gi] = sync_reg;
    end
  endgenerate

endmodule : pmrs_sync2

// >>> verilog/pmrs_sequencer.sv
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Power-on, low voltage, reset pin low or watchdog timeout enters reset.
// - Reset loads registers with defined values; undefined ones keep contents.
// - Power-on or low-voltage reset sets both status flags to one.
// - Pin reset keeps flags outside halt; from halt sets both to one.
// - Watchdog reset outside halt: timeout flag zero, powerdown flag one.
// - Watchdog reset in halt clears both flags to zero.
// - Halt instruction clears powerdown flag and sets timeout flag.
// - Watchdog clear instruction sets both flags to one.
// - Sequence starts only after every reset cause has been released.
// - Wait selectable stabilization time: 140u, 4.5m, 18m, 72m, 288m.
// - Then count 16 oscillator cycles before the sequence completes.
// - Start in normal or slow mode by startup clock setting.
// - Oscillator enables follow mode; halt stops both oscillators.
// - Execute in normal and slow; timers, modules off in halt.
// - Watchdog runs by option and enable bit in every mode.
// - Standby and halt each wake only on their own source sets.
// - Halt wake-up waits 16 oscillator cycles; standby wake is immediate.
module pmrs_sequencer #(
  parameter int STAB0_CYCLES = pmrs_pkg::STAB0_CYCLES,
  parameter int STAB1_CYCLES = pmrs_pkg::STAB1_CYCLES,
  parameter int STAB2_CYCLES = pmrs_pkg::STAB2_CYCLES,
  parameter int STAB3_CYCLES = pmrs_pkg::STAB3_CYCLES,
  parameter int STAB4_CYCLES = pmrs_pkg::STAB4_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // reset sources and wake events
  input wire logic por_i,
  input wire logic low_voltage_reset_event_i,
  input wire logic reset_pin_n_i,
  input wire logic wdt_timeout_i,
  input wire logic timer0_overflow_i,
  input wire logic timer1_underflow_i,
  input wire logic portb_change_i,
  input wire logic ext_int_i,
  input wire logic low_voltage_detect_event_i,
  // core instruction strobes
  input wire logic halt_instruction_i,
  input wire logic watchdog_clear_instruction_i,
  // gating outputs
  output logic sys_reset_n_o,
  output logic exec_en_o,
  output logic high_osc_en_o,
  output logic low_osc_en_o,
  output logic timer0_run_o,
  output logic timer1_run_o,
  output logic [pmrs_pkg::MOD_EN_W-1:0] module_en_o,
  output logic watchdog_run_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o,
  output logic irq_o
);
  import pmrs_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  pmrs_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] cfg_reg;
  logic [2:0] cause_reg;
  logic timeout_flag_n_reg;
  logic powerdown_flag_n_reg;
  logic [INT_W-1:0] int_stat_reg;
  logic [INT_W-1:0] int_en_reg;
  logic dph_wr_reg;
  logic [ADDR_W-1:0] dph_addr_reg;
  logic [31:0] hrdata_reg;
  logic [5:0] sync_w;
  logic por_s, lvr_s, pin_n_s, portb_s, ext_s, lvd_s;
  logic wdt_rst, cause_any, in_seq, run_mode, in_halt;
  logic halt_req, standby_req, wake_standby, wake_halt, wake_evt;
  logic ost_done, sel_high;
  logic [CNT_W-1:0] stab_last;
  logic [1:0] opmd_cmd;
  logic [1:0] mode_code;
  logic bus_take;
  logic wr_ctrl, wr_cfg, wr_int_en, wr_int_clr;
  logic [INT_W-1:0] int_set;
  logic [31:0] rd_word;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pmrs_sync2 #(.W(6), .RST_VAL(6'h04)) u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i({low_voltage_detect_event_i, ext_int_i, portb_change_i,
              reset_pin_n_i, low_voltage_reset_event_i, por_i}),
    .sync_o(sync_w)
  );
  assign por_s = sync_w[0];
  assign lvr_s = sync_w[1];
  assign pin_n_s = sync_w[2];
  assign portb_s = sync_w[3];
  assign ext_s = sync_w[4];
  assign lvd_s = sync_w[5];

  // ****************************************************************
  // reset causes, mode requests and wake sources
  // ****************************************************************
  // watchdog timeout is a reset only when configured so
  assign wdt_rst = wdt_timeout_i & cfg_reg[CFG_WDT_RESET];
  assign cause_any = por_s | lvr_s | ~pin_n_s | wdt_rst;
  assign in_seq = (state_reg == S_RESET) | (state_reg == S_STAB)
                | (state_reg == S_OST);
  assign run_mode = (state_reg == S_NORMAL) | (state_reg == S_SLOW);
  assign in_halt = (state_reg == S_HALT) | (state_reg == S_WAKE);
  assign sel_high = ctrl_reg[CTRL_SEL_HIGH];
  assign opmd_cmd = wr_ctrl ? hwdata_i[CTRL_OPMD_LO +: 2] : 2'h0;
  assign halt_req = run_mode
                  & (halt_instruction_i | (opmd_cmd == OPMD_HALT));
  assign standby_req = run_mode & (opmd_cmd == OPMD_STANDBY);
  // standby keeps timers and supply detect alive, halt does not
  assign wake_standby = timer0_overflow_i | timer1_underflow_i
                      | wdt_timeout_i | portb_s | ext_s | lvd_s;
  assign wake_halt = wdt_timeout_i | portb_s | ext_s;
  assign wake_evt = ~cause_any
                  & (((state_reg == S_STANDBY) & wake_standby)
                  | ((state_reg == S_HALT) & wake_halt));
  assign ost_done = (state_reg == S_OST) & ~cause_any
                  & (cnt_reg == CNT_W'(OST_CYCLES - 1));

  // stabilization length picked by the configuration word
  always_comb begin
    case (cfg_reg[CFG_STAB_LO +: 3])
      3'h0: stab_last = CNT_W'(STAB0_CYCLES - 1);
      3'h1: stab_last = CNT_W'(STAB1_CYCLES - 1);
      3'h2: stab_last = CNT_W'(STAB2_CYCLES - 1);
      3'h3: stab_last = CNT_W'(STAB3_CYCLES - 1);
      default: stab_last = CNT_W'(STAB4_CYCLES - 1);
    endcase
  end

  // ****************************************************************
  // mode and reset sequence state machine
  // ****************************************************************
  // any live cause pins the machine in reset until it is released
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= S_RESET;
      cnt_reg <= '0;
    end else if (cause_any) begin
      state_reg <= S_RESET;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        S_RESET: begin
          state_reg <= S_STAB;
          cnt_reg <= '0;
        end
        S_STAB: begin
          if (cnt_reg == stab_last) begin
            state_reg <= S_OST;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        S_OST: begin
          if (ost_done) begin
            cnt_reg <= '0;
            if (cfg_reg[CFG_STARTUP_HIGH]) begin
              state_reg <= S_NORMAL;
            end else begin
              state_reg <= S_SLOW;
            end
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        S_NORMAL, S_SLOW: begin
          if (halt_req) begin
            state_reg <= S_HALT;
          end else if (standby_req) begin
            state_reg <= S_STANDBY;
          end else begin
            state_reg <= sel_high ? S_NORMAL : S_SLOW;
          end
        end
        S_STANDBY: begin
          if (wake_standby) begin
            state_reg <= sel_high ? S_NORMAL : S_SLOW;
          end
        end
        S_HALT: begin
          if (wake_halt) begin
            state_reg <= S_WAKE;
            cnt_reg <= '0;
          end
        end
        S_WAKE: begin
          if (cnt_reg == CNT_W'(WAKE_CYCLES - 1)) begin
            state_reg <= sel_high ? S_NORMAL : S_SLOW;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= S_RESET;
          cnt_reg <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // timeout and powerdown flags
  // ****************************************************************
  // supply resets win, then watchdog, then pin, then instructions
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end else if (por_s | lvr_s) begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end else if (wdt_rst & (state_reg != S_RESET)) begin
      timeout_flag_n_reg <= 1'b0;
      powerdown_flag_n_reg <= ~in_halt;
    end else if (~pin_n_s & (state_reg != S_RESET) & in_halt) begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end else if (~cause_any & halt_req) begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b0;
    end else if (~cause_any & run_mode & watchdog_clear_instruction_i) begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end
  end

  // last reset cause, kept across the sequence
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cause_reg <= 3'h1;
    end else if (cause_any & (state_reg != S_RESET)) begin
      cause_reg <= {wdt_rst, ~pin_n_s, por_s | lvr_s};
    end
  end

  // ****************************************************************
  // ahb-lite slave, zero wait states
  // ****************************************************************
  assign bus_take = hsel_i & htrans_i[1] & hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_reg;
  assign wr_ctrl = dph_wr_reg & (dph_addr_reg == ADDR_CTRL);
  assign wr_cfg = dph_wr_reg & (dph_addr_reg == ADDR_CFG);
  assign wr_int_en = dph_wr_reg & (dph_addr_reg == ADDR_INT_EN);
  assign wr_int_clr = dph_wr_reg & (dph_addr_reg == ADDR_INT_CLR);

  // read mux, unmapped and write-only words read zero
  always_comb begin
    rd_word = 32'h0;
    case (haddr_i[ADDR_W-1:0])
      ADDR_CTRL: rd_word = ctrl_reg;
      ADDR_CFG: rd_word = cfg_reg;
      ADDR_STATUS: begin
        rd_word[STAT_MODE_LO +: 2] = mode_code;
        rd_word[STAT_IN_RESET] = in_seq;
        rd_word[STAT_PD_N] = powerdown_flag_n_reg;
        rd_word[STAT_TO_N] = timeout_flag_n_reg;
        rd_word[STAT_CAUSE_LO +: 3] = cause_reg;
      end
      ADDR_INT_STAT: rd_word[INT_W-1:0] = int_stat_reg;
      ADDR_INT_EN: rd_word[INT_W-1:0] = int_en_reg;
      default: rd_word = 32'h0;
    endcase
  end

  // address phase capture; read data sampled at the address phase
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dph_wr_reg <= 1'b0;
      dph_addr_reg <= '0;
      hrdata_reg <= 32'h0;
    end else begin
      dph_wr_reg <= bus_take & hwrite_i;
      dph_addr_reg <= haddr_i[ADDR_W-1:0];
      if (bus_take & ~hwrite_i) begin
        hrdata_reg <= rd_word;
      end
    end
  end

  // control word: reloaded during reset, startup clock at completion
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (state_reg == S_RESET) begin
      ctrl_reg <= CTRL_RST;
    end else if (ost_done) begin
      ctrl_reg[CTRL_SEL_HIGH] <= cfg_reg[CFG_STARTUP_HIGH];
    end else if (wr_ctrl) begin
      ctrl_reg <= hwdata_i & CTRL_WMASK;
    end
  end

  // configuration survives device resets, like option words
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg <= CFG_RST;
    end else if (wr_cfg) begin
      cfg_reg <= hwdata_i & CFG_WMASK;
    end
  end

  // ****************************************************************
  // interrupts: sticky status, set wins over clear
  // ****************************************************************
  assign int_set = {wdt_timeout_i, ost_done, wake_evt};
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_stat_reg <= '0;
      int_en_reg <= '0;
    end else begin
      int_stat_reg <= (int_stat_reg
                    & ~(wr_int_clr ? hwdata_i[INT_W-1:0] : '0)) | int_set;
      if (wr_int_en) begin
        int_en_reg <= hwdata_i[INT_W-1:0];
      end
    end
  end
  assign irq_o = |(int_stat_reg & int_en_reg);

  // ****************************************************************
  // gating outputs
  // ****************************************************************
  always_comb begin
    case (state_reg)
      S_SLOW: mode_code = MODE_SLOW;
      S_STANDBY: mode_code = MODE_STANDBY;
      S_HALT, S_WAKE: mode_code = MODE_HALT;
      default: mode_code = MODE_NORMAL;
    endcase
  end
  assign sys_reset_n_o = ~in_seq;
  assign exec_en_o = run_mode;
  // high oscillator obeys stop bit in slow and standby only
  assign high_osc_en_o = (state_reg == S_HALT) ? 1'b0
                       : ((state_reg == S_SLOW) | (state_reg == S_STANDBY))
                       ? ~ctrl_reg[CTRL_STOP_HOSC] : 1'b1;
  assign low_osc_en_o = (state_reg != S_HALT);
  assign timer0_run_o = ctrl_reg[CTRL_TIMER0_ENABLE] & ~in_halt & ~in_seq;
  assign timer1_run_o = ctrl_reg[CTRL_TIMER1_ENABLE] & ~in_halt & ~in_seq;
  assign module_en_o = (in_halt | in_seq) ? '0
                     : ctrl_reg[CTRL_MOD_LO +: MOD_EN_W];
  assign watchdog_run_o = cfg_reg[CFG_WDT_OPT]
                        & ctrl_reg[CTRL_WATCHDOG_ENABLE];
  assign timeout_flag_n_o = timeout_flag_n_reg;
  assign powerdown_flag_n_o = powerdown_flag_n_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  chk_cause_enters_reset: assert property (
    cause_any |=> (state_reg == S_RESET) && !sys_reset_n_o)
    else $error("reset cause did not enter reset");
  chk_supply_flags: assert property (
    (por_s || lvr_s) |=> timeout_flag_n_o && powerdown_flag_n_o)
    else $error("supply reset did not set both flags");
  chk_pin_nonhalt_flags: assert property (
    (!pin_n_s && !por_s && !lvr_s && !wdt_rst && !in_halt)
    |=> $stable(timeout_flag_n_o) && $stable(powerdown_flag_n_o))
    else $error("pin reset outside halt changed flags");
  chk_wdt_flags: assert property (
    (wdt_rst && !por_s && !lvr_s && state_reg != S_RESET)
    |=> !timeout_flag_n_o && (powerdown_flag_n_o == !$past(in_halt)))
    else $error("watchdog reset flags wrong");
  chk_halt_instr_flags: assert property (
    (halt_req && !cause_any) |=> timeout_flag_n_o && !powerdown_flag_n_o
    && state_reg == S_HALT)
    else $error("halt entry flags wrong");
  chk_hold_in_reset: assert property (
    (state_reg == S_RESET && cause_any) |=> state_reg == S_RESET)
    else $error("sequence began with a live cause");
  chk_ost_length: assert property (
    ($rose(state_reg == S_OST)) |-> (state_reg == S_OST)[*8]
    ##1 ((state_reg == S_OST)[*8] or (state_reg == S_RESET)))
    else $error("start-up count too short");
  chk_halt_osc_off: assert property (
    (state_reg == S_HALT) |-> !high_osc_en_o && !low_osc_en_o
    && !timer0_run_o && module_en_o == '0)
    else $error("halt left clocks or modules running");
  chk_exec_gate: assert property (
    in_seq |-> !exec_en_o && !sys_reset_n_o && !timer1_run_o)
    else $error("core released during sequence");
  chk_halt_wake_wait: assert property (
    (state_reg == S_HALT && wake_halt && !cause_any) |=>
    (state_reg == S_WAKE)[*8] ##8 !exec_en_o
    ##1 (exec_en_o || state_reg == S_RESET))
    else $error("halt wake wait is not sixteen cycles");
  chk_irq_level: assert property (
    (int_stat_reg[INT_WAKE] && int_en_reg[INT_WAKE]) |-> irq_o)
    else $error("enabled event did not raise interrupt");

  cov_reset_complete: cover property (ost_done);
  cov_halt_wake: cover property (state_reg == S_WAKE ##1 exec_en_o);
  cov_standby_wake: cover property (state_reg == S_STANDBY ##1 run_mode);
  cov_wdt_halt: cover property (wdt_rst && state_reg == S_HALT);

endmodule : pmrs_sequencer

// >>> testbench/pmrs_far_model.sv
`timescale 1ns/1ps
// far side: supply monitors, reset pin, watchdog, timer and core strobes
// bits: 0 por, 1 low voltage, 2 pin, 3 wdt, 4 halt, 5 clear, 6 t0, 7 ext
// bits: 8 t1 underflow, 9 port-b change, 10 low voltage detect
module pmrs_far_model (
  input wire logic clock_i,
  output logic [10:0] ev_o
);
  initial ev_o = 11'h000;
  // raise one line for n cycles, changed only just after an edge
  task automatic fire(input int b, input int n);
    ev_o[b] <= 1'b1;
    repeat (n) @(posedge clock_i);
    ev_o[b] <= 1'b0;
  endtask : fire
endmodule : pmrs_far_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pmrs_pkg::*;
  logic clock_i = 0;
  logic nrst_i = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hready, hresp, srst_n, exec, hosc, losc, t0r, t1r, wdr, to_n, pd_n;
  logic irq;
  logic [3:0] men;
  logic [10:0] ev;
  int n_mismatch = 0;
  int samples_checked = 0;
  // 4 ns system clock
  initial forever #2 clock_i = ~clock_i;
  pmrs_far_model far (.clock_i(clock_i), .ev_o(ev));
  // a short first stabilization count keeps the run brief
  pmrs_sequencer #(.STAB0_CYCLES(20)) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .por_i(ev[0]),
    .low_voltage_reset_event_i(ev[1]), .reset_pin_n_i(~ev[2]),
    .wdt_timeout_i(ev[3]), .timer0_overflow_i(ev[6]),
    .timer1_underflow_i(ev[8]), .portb_change_i(ev[9]), .ext_int_i(ev[7]),
    .low_voltage_detect_event_i(ev[10]), .halt_instruction_i(ev[4]),
    .watchdog_clear_instruction_i(ev[5]), .sys_reset_n_o(srst_n),
    .exec_en_o(exec), .high_osc_en_o(hosc), .low_osc_en_o(losc),
    .timer0_run_o(t0r), .timer1_run_o(t1r), .module_en_o(men),
    .watchdog_run_o(wdr), .timeout_flag_n_o(to_n),
    .powerdown_flag_n_o(pd_n), .irq_o(irq));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h want %h", $time, g, e);
    end
  endtask : chk
  // single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clock_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_i); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  // cycles until execution resumes must fall in lo..hi
  task automatic run(input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (exec !== 1'b1 && n < 400);
    @(posedge clock_i);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask : run
  // let an event land, then look at both flags
  task automatic flags(input logic t, input logic p);
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    chk(32'({to_n, pd_n}), 32'({t, p}));
    @(posedge clock_i);
  endtask : flags
  task automatic halt_in;
    far.fire(4, 1);
    repeat (3) @(posedge clock_i);
  endtask : halt_in
  task automatic irq_is(input logic e);
    @(negedge clock_i);
    chk(32'(irq), 32'(e));
    @(posedge clock_i);
  endtask : irq_is
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_boot;
    run(36, 44);
    flags(1'b1, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(q[1:0]), 32'(MODE_NORMAL));
    bus(1'b0, ADDR_CFG, 32'h0);
    chk(q, CFG_RST);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk(32'(hresp), 32'h0);
  endtask : t_boot
  // reset-done interrupt: enabled, masked, cleared
  task automatic t_irq;
    bus(1'b1, ADDR_INT_EN, 32'h2);
    irq_is(1'b1);
    bus(1'b1, ADDR_INT_EN, 32'h0);
    irq_is(1'b0);
    bus(1'b1, ADDR_INT_EN, 32'h2);
    bus(1'b1, ADDR_INT_CLR, 32'h2);
    bus(1'b0, ADDR_INT_STAT, 32'h0);
    chk(q, 32'h0);
    irq_is(1'b0);
  endtask : t_irq
  task automatic t_halt;
    halt_in;
    @(negedge clock_i);
    chk(32'({exec, hosc, losc, t0r, t1r, men}), 32'h0);
    chk(32'(wdr), 32'h1);
    chk(32'({to_n, pd_n}), 32'h2);
    @(posedge clock_i);
    far.fire(6, 1);
    far.fire(8, 1);
    far.fire(10, 3);
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    chk(32'(exec), 32'h0);
    @(posedge clock_i);
    far.fire(7, 2);
    run(16, 20);
  endtask : t_halt
  // standby wakes on timer0, timer1, port-b change and low voltage detect
  task automatic t_standby;
    bus(1'b1, ADDR_CTRL, 32'h59);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk(32'({exec, t0r, hosc, losc}), 32'h7);
    @(posedge clock_i);
    far.fire(6, 1);
    run(1, 3);
    bus(1'b1, ADDR_CTRL, 32'h59);
    far.fire(8, 1);
    run(1, 3);
    bus(1'b1, ADDR_CTRL, 32'h59);
    far.fire(9, 3);
    run(1, 3);
    bus(1'b1, ADDR_CTRL, 32'h59);
    far.fire(10, 3);
    run(1, 3);
  endtask : t_standby
  task automatic t_flags;
    halt_in;
    far.fire(3, 1);
    flags(1'b0, 1'b0);
    run(10, 60);
    far.fire(2, 3);
    flags(1'b0, 1'b0);
    run(10, 60);
    halt_in;
    far.fire(2, 3);
    flags(1'b1, 1'b1);
    run(10, 60);
    far.fire(3, 1);
    flags(1'b0, 1'b1);
    run(10, 60);
    far.fire(5, 1);
    flags(1'b1, 1'b1);
    far.fire(3, 1);
    run(10, 60);
    far.fire(1, 3);
    flags(1'b1, 1'b1);
    far.fire(2, 60);
    @(negedge clock_i);
    chk(32'({srst_n, exec}), 32'h0);
    @(posedge clock_i);
    run(36, 44);
  endtask : t_flags
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // reset for five cycles, then the scenarios
  initial begin
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_boot;
    t_irq;
    t_halt;
    t_standby;
    t_flags;
    stop_test;
  end
  // hang guard, far beyond the expected run
  initial begin
    #100000;
    n_mismatch++;
    stop_test;
  end
endmodule : testbench
